// [verilog/afud_pkg.sv]
// Shared constants and types for the alpha-field character decoder
package afud_pkg;
    // ------------------------------------------------------------------
    // Header codes and octet values
    // ------------------------------------------------------------------
    localparam logic [7:0] AFUD_HDR_PAIR = 8'h80; // Plain 16-bit pairs
    localparam logic [7:0] AFUD_HDR_BASE8 = 8'h81; // 8-bit half-page base
    localparam logic [7:0] AFUD_HDR_BASE16 = 8'h82; // 16-bit half-page base
    localparam logic [7:0] AFUD_PAD_OCTET = 8'hFF; // Filler octet
    localparam logic [15:0] AFUD_PAD_PAIR = 16'hFFFF; // Filler character in pair scheme
    localparam logic [7:0] AFUD_CNT_ZERO = 8'h00; // Character count exhausted
    localparam logic [7:0] AFUD_CNT_STEP = 8'h01; // One character consumed
    localparam logic [6:0] AFUD_BASE8_LOW = 7'h00; // Low bits of an 8-bit base
    localparam logic [8:0] AFUD_DEF_HIGH = 9'h000; // High bits of a 7-bit character
    localparam int AFUD_FLAG_BIT = 7; // Offset or default-char select bit
    // ------------------------------------------------------------------
    // Buffer sizing
    // ------------------------------------------------------------------
    localparam int AFUD_FIFO_DEPTH = 8;
    // Ready is withdrawn while fewer than this many slots remain free
    localparam int AFUD_FIFO_MARGIN = 2;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic is_ucs2; // 1: 16-bit code point, 0: 7-bit default char
        logic eor; // End-of-record marker, code is zero
        logic [15:0] code; // Code point or default char in low bits
    } afud_chr_s;
    localparam int AFUD_CHR_W = $bits(afud_chr_s);
    typedef enum logic [3:0] {
        AFUD_ST_HDR = 4'h0, // Waiting for the first octet
        AFUD_ST_PAIR_HI = 4'h1, // Expect upper_char_octet
        AFUD_ST_PAIR_LO = 4'h2, // Expect lower_char_octet
        AFUD_ST_COUNT = 4'h3, // Expect character count
        AFUD_ST_BASE8 = 4'h4, // Expect 8-bit base
        AFUD_ST_BASE_HI = 4'h5, // Expect upper base octet
        AFUD_ST_BASE_LO = 4'h6, // Expect lower base octet
        AFUD_ST_BODY = 4'h7, // Counted body octets
        AFUD_ST_DEFLT = 4'h8, // Default-alphabet record
        AFUD_ST_DRAIN = 4'h9, // Discard rest of record
        AFUD_ST_END = 4'hA // Push end marker
    } afud_state_e;
endpackage

// [verilog/afud_decoder.sv]
// Alpha-field decoder with its character FIFO
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Character FIFO
// ----------------------------------------------------------------------
module afud_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    // Handshakes and pointer arithmetic
    always_comb begin
        o_in_ready = (cnt_reg != CNT_FULL);
        o_out_valid = (cnt_reg != '0);
        o_out_data = mem_reg[rd_ptr_reg];
        o_count = cnt_reg;
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
        end
        cnt_next = cnt_reg + CW'(push) - CW'(pop);
    end

    // Storage is written without reset; only pointers and count need a value
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Decoder top
// ----------------------------------------------------------------------
// Functional notes
// - First octet picks pair, base8, base16, default
// - Pair scheme: upper octet first from octet 2
// - Base8: octet 2 bounds character count
// - Base8 pointer is octet 3 shifted seven
// - Base8 body: bit7 selects offset or default
// - Base16: count, then two-octet base upper first
// - Base16 body: bit7 selects offset or default
// - FF inside count is offset 7F
// - All three schemes supported, any set size
module afud_decoder (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_oct_valid, // Octet strobe from record reader
    input wire logic [7:0] i_oct_data, // Record octet
    input wire logic i_oct_last, // Last octet of the record
    output logic o_oct_ready, // Decoder can take an octet
    output logic o_chr_valid, // Character strobe
    input wire logic i_chr_ready, // Consumer takes the character
    output afud_pkg::afud_chr_s o_chr // Decoded character
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    afud_pkg::afud_state_e st_reg, st_next;
    logic [7:0] cnt_reg, cnt_next; // Characters still to decode
    logic [15:0] base_reg, base_next; // Half-page base pointer
    logic [7:0] hi_reg, hi_next; // Held upper octet
    logic rdy_reg, rdy_next; // Registered ready
    logic ov_reg, ov_next; // Output valid
    afud_pkg::afud_chr_s oc_reg, oc_next; // Output character
    logic take; // Octet accepted this cycle
    logic push; // Entry written to FIFO
    afud_pkg::afud_chr_s push_chr;
    logic f_in_ready, f_out_valid, f_pop;
    logic [afud_pkg::AFUD_CHR_W-1:0] f_out_data;
    logic [$clog2(afud_pkg::AFUD_FIFO_DEPTH+1)-1:0] f_count;
    afud_pkg::afud_chr_s body_chr; // Decoded body octet

    assign take = i_oct_valid && rdy_reg;

    // Body octet: clear top bit is a default char, set bit an offset
    always_comb begin
        body_chr = '0;
        if (i_oct_data[afud_pkg::AFUD_FLAG_BIT]) begin
            body_chr.is_ucs2 = 1'b1;
            body_chr.code = base_reg + {afud_pkg::AFUD_DEF_HIGH, i_oct_data[6:0]};
        end else begin
            body_chr.code = {afud_pkg::AFUD_DEF_HIGH, i_oct_data[6:0]};
        end
    end

    // ------------------------------------------------------------------
    // Record parser
    // ------------------------------------------------------------------
    // Each accepted octet pushes at most one entry, so registered ready
    // with a two-slot margin can never overflow the FIFO
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        base_next = base_reg;
        hi_next = hi_reg;
        push = 1'b0;
        push_chr = '0;
        if (st_reg == afud_pkg::AFUD_ST_END) begin
            // End marker waits for room; octets are held off meanwhile
            push_chr.eor = 1'b1;
            if (f_in_ready) begin
                push = 1'b1;
                st_next = afud_pkg::AFUD_ST_HDR;
            end
        end else if (take) begin
            case (st_reg)
                afud_pkg::AFUD_ST_HDR: begin
                    // Scheme select on the first octet
                    if (i_oct_data == afud_pkg::AFUD_HDR_PAIR) begin
                        st_next = afud_pkg::AFUD_ST_PAIR_HI;
                    end else if (i_oct_data == afud_pkg::AFUD_HDR_BASE8) begin
                        st_next = afud_pkg::AFUD_ST_COUNT;
                        hi_next = afud_pkg::AFUD_HDR_BASE8;
                    end else if (i_oct_data == afud_pkg::AFUD_HDR_BASE16) begin
                        st_next = afud_pkg::AFUD_ST_COUNT;
                        hi_next = afud_pkg::AFUD_HDR_BASE16;
                    end else begin
                        st_next = afud_pkg::AFUD_ST_DEFLT;
                        if (i_oct_data != afud_pkg::AFUD_PAD_OCTET) begin
                            push = 1'b1;
                            push_chr.code = {afud_pkg::AFUD_DEF_HIGH, i_oct_data[6:0]};
                        end
                    end
                end
                afud_pkg::AFUD_ST_PAIR_HI: begin
                    // A lone trailing octet is the unusable filler
                    hi_next = i_oct_data;
                    st_next = afud_pkg::AFUD_ST_PAIR_LO;
                end
                afud_pkg::AFUD_ST_PAIR_LO: begin
                    if ({hi_reg, i_oct_data} == afud_pkg::AFUD_PAD_PAIR) begin
                        st_next = afud_pkg::AFUD_ST_DRAIN;
                    end else begin
                        push = 1'b1;
                        push_chr.is_ucs2 = 1'b1;
                        push_chr.code = {hi_reg, i_oct_data};
                        st_next = afud_pkg::AFUD_ST_PAIR_HI;
                    end
                end
                afud_pkg::AFUD_ST_COUNT: begin
                    cnt_next = i_oct_data;
                    st_next = (hi_reg == afud_pkg::AFUD_HDR_BASE8) ?
                        afud_pkg::AFUD_ST_BASE8 : afud_pkg::AFUD_ST_BASE_HI;
                end
                afud_pkg::AFUD_ST_BASE8: begin
                    base_next = {1'b0, i_oct_data, afud_pkg::AFUD_BASE8_LOW};
                    st_next = (cnt_reg == afud_pkg::AFUD_CNT_ZERO) ?
                        afud_pkg::AFUD_ST_DRAIN : afud_pkg::AFUD_ST_BODY;
                end
                afud_pkg::AFUD_ST_BASE_HI: begin
                    hi_next = i_oct_data;
                    st_next = afud_pkg::AFUD_ST_BASE_LO;
                end
                afud_pkg::AFUD_ST_BASE_LO: begin
                    base_next = {hi_reg, i_oct_data};
                    st_next = (cnt_reg == afud_pkg::AFUD_CNT_ZERO) ?
                        afud_pkg::AFUD_ST_DRAIN : afud_pkg::AFUD_ST_BODY;
                end
                afud_pkg::AFUD_ST_BODY: begin
                    // Inside the count every octet, FF included, is a char
                    push = 1'b1;
                    push_chr = body_chr;
                    cnt_next = cnt_reg - afud_pkg::AFUD_CNT_STEP;
                    if (cnt_reg == afud_pkg::AFUD_CNT_STEP) begin
                        st_next = afud_pkg::AFUD_ST_DRAIN;
                    end
                end
                afud_pkg::AFUD_ST_DEFLT: begin
                    // Filler octets carry no character
                    if (i_oct_data != afud_pkg::AFUD_PAD_OCTET) begin
                        push = 1'b1;
                        push_chr.code = {afud_pkg::AFUD_DEF_HIGH, i_oct_data[6:0]};
                    end
                end
                afud_pkg::AFUD_ST_DRAIN: begin
                    st_next = afud_pkg::AFUD_ST_DRAIN;
                end
                default: begin
                    st_next = afud_pkg::AFUD_ST_HDR;
                end
            endcase
            // Every record, however short, closes with a marker
            if (i_oct_last) begin
                st_next = afud_pkg::AFUD_ST_END;
            end
        end
        rdy_next = (f_count <= 4'(afud_pkg::AFUD_FIFO_DEPTH - afud_pkg::AFUD_FIFO_MARGIN))
            && (st_next != afud_pkg::AFUD_ST_END);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st_reg <= afud_pkg::AFUD_ST_HDR;
            cnt_reg <= '0;
            base_reg <= '0;
            hi_reg <= '0;
            rdy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            base_reg <= base_next;
            hi_reg <= hi_next;
            rdy_reg <= rdy_next;
        end
    end

    // ------------------------------------------------------------------
    // Buffer and output stage
    // ------------------------------------------------------------------
    afud_fifo #(
        .WIDTH(afud_pkg::AFUD_CHR_W),
        .DEPTH(afud_pkg::AFUD_FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_in_valid(push),
        .o_in_ready(f_in_ready),
        .i_in_data(push_chr),
        .o_out_valid(f_out_valid),
        .i_out_ready(f_pop),
        .o_out_data(f_out_data),
        .o_count(f_count)
    );

    // Output register refills whenever empty or being taken
    always_comb begin
        f_pop = !ov_reg || i_chr_ready;
        ov_next = ov_reg;
        oc_next = oc_reg;
        if (f_pop) begin
            ov_next = f_out_valid;
            oc_next = f_out_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            ov_reg <= 1'b0;
            oc_reg <= '0;
        end else begin
            ov_reg <= ov_next;
            oc_reg <= oc_next;
        end
    end

    assign o_oct_ready = rdy_reg;
    assign o_chr_valid = ov_reg;
    assign o_chr = oc_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    a_hdr_pair_sel: assert property (
        st_reg == afud_pkg::AFUD_ST_HDR && take && !i_oct_last &&
        i_oct_data == afud_pkg::AFUD_HDR_PAIR |=> st_reg == afud_pkg::AFUD_ST_PAIR_HI)
        else $error("pair header not selected");
    a_hdr_count_sel: assert property (
        st_reg == afud_pkg::AFUD_ST_HDR && take && !i_oct_last &&
        (i_oct_data == afud_pkg::AFUD_HDR_BASE8 || i_oct_data == afud_pkg::AFUD_HDR_BASE16)
        |=> st_reg == afud_pkg::AFUD_ST_COUNT)
        else $error("base header not selected");
    a_pair_order: assert property (
        st_reg == afud_pkg::AFUD_ST_PAIR_LO && take && push |->
        push_chr.code == {hi_reg, i_oct_data} && push_chr.is_ucs2)
        else $error("pair octet order wrong");
    a_count_load: assert property (
        st_reg == afud_pkg::AFUD_ST_COUNT && take |=> cnt_reg == $past(i_oct_data))
        else $error("count not loaded");
    a_base8_form: assert property (
        st_reg == afud_pkg::AFUD_ST_BASE8 && take |=>
        base_reg == {1'b0, $past(i_oct_data), afud_pkg::AFUD_BASE8_LOW})
        else $error("base8 pointer wrong");
    a_base16_form: assert property (
        st_reg == afud_pkg::AFUD_ST_BASE_HI && take ##1
        st_reg == afud_pkg::AFUD_ST_BASE_LO && take |=>
        base_reg == {$past(i_oct_data, 2), $past(i_oct_data)})
        else $error("base16 pointer wrong");
    a_body_offset: assert property (
        st_reg == afud_pkg::AFUD_ST_BODY && take |-> push &&
        push_chr.is_ucs2 == i_oct_data[7] &&
        (i_oct_data[7] || push_chr.code[15:7] == afud_pkg::AFUD_DEF_HIGH))
        else $error("body octet misdecoded");
    a_ff_is_char: assert property (
        st_reg == afud_pkg::AFUD_ST_BODY && take &&
        i_oct_data == afud_pkg::AFUD_PAD_OCTET |->
        push && push_chr.code == base_reg + 16'h007F)
        else $error("FF in count not a char");
    a_count_bound: assert property (
        st_reg == afud_pkg::AFUD_ST_BODY && take &&
        cnt_reg == afud_pkg::AFUD_CNT_STEP && !i_oct_last |=>
        st_reg == afud_pkg::AFUD_ST_DRAIN)
        else $error("count overrun");
    a_end_marker: assert property (
        take && i_oct_last |=> ##[0:20] (push && push_chr.eor))
        else $error("end marker missing");
    a_out_hold: assert property (
        o_chr_valid && !i_chr_ready |=> o_chr_valid && $stable(o_chr))
        else $error("output dropped under stall");

    c_pair_char: cover property (push && push_chr.is_ucs2 && st_reg == afud_pkg::AFUD_ST_PAIR_LO);
    c_base_ff: cover property (st_reg == afud_pkg::AFUD_ST_BODY && take &&
        i_oct_data == afud_pkg::AFUD_PAD_OCTET);
    c_fifo_full: cover property (!f_in_ready);
    c_marker_out: cover property (o_chr_valid && i_chr_ready && o_chr.eor);
endmodule

// [tb/afud_rec_reader.sv]
// Behavioural record reader that hands record octets to the decoder
`timescale 1ns/1ps

// ----------
// Record reader model
// ----------
module afud_rec_reader (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_oct_ready,
    input wire logic i_slow,
    output logic o_oct_valid,
    output logic [7:0] o_oct_data,
    output logic o_oct_last
);
    logic [8:0] oct_q[$]; // Pending octets, last flag in bit 8
    logic took_reg; // Octet was taken at the last rising edge

    // Whole records only; the writer chooses one scheme and pads with FF
    task automatic put_record(input logic [7:0] rec[$]);
        for (int i = 0; i < rec.size(); i++) begin
            oct_q.push_back({(i == rec.size() - 1), rec[i]});
        end
    endtask

    // Note the take at the sampling edge
    always @(posedge i_clk_sys) begin
        took_reg <= i_rst_b && o_oct_valid && i_oct_ready;
    end

    // Change only after the falling edge; the strobe is written once per step,
    // so a taken octet is either replaced at once or the strobe drops
    always @(negedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_oct_valid = 1'b0;
            o_oct_data = 8'hA5;
            o_oct_last = 1'b0;
        end else if (took_reg || !o_oct_valid) begin
            if (oct_q.size() != 0 && (!i_slow || $urandom_range(3) == 0)) begin
                {o_oct_last, o_oct_data} = oct_q.pop_front();
                o_oct_valid = 1'b1;
            end else begin
                // Idle lines toggle so stale data never looks valid
                o_oct_valid = 1'b0;
                o_oct_data = ~o_oct_data;
                o_oct_last = ~o_oct_last;
            end
        end
    end
endmodule

// [tb/alpha_field_ucs2_decoder_tb_top.sv]
// Self-checking bench for the alpha-field character decoder
`timescale 1ns/1ps

module alpha_field_ucs2_decoder_tb_top;
    // ----------
    // Signals
    // ----------
    logic i_clk_sys; // 10 MHz system clock
    logic i_rst_b; // Synchronous reset, active low
    logic slow; // Reader leaves gaps between octets
    logic stall; // Consumer refuses all characters
    logic chr_ready; // Consumer ready
    logic oct_valid;
    logic [7:0] oct_data;
    logic oct_last;
    logic oct_ready;
    logic chr_valid;
    afud_pkg::afud_chr_s chr;
    afud_pkg::afud_chr_s exp_q[$]; // Characters still expected, in order
    logic [7:0] rec[$]; // Record under construction
    logic [17:0] held; // Character shown while consumer stalled
    logic held_ok;
    int fail_count;
    int cmp_count;
    int cyc;
    int sel;
    int n;

    initial begin
        i_clk_sys = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        cyc = 0;
    end
    always #50 i_clk_sys = ~i_clk_sys;

    afud_rec_reader u_afud_rec_reader (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_oct_ready(oct_ready), .i_slow(slow), .o_oct_valid(oct_valid),
        .o_oct_data(oct_data), .o_oct_last(oct_last));
    afud_decoder u_afud_decoder (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_oct_valid(oct_valid), .i_oct_data(oct_data), .i_oct_last(oct_last),
        .o_oct_ready(oct_ready), .o_chr_valid(chr_valid), .i_chr_ready(chr_ready), .o_chr(chr));

    // ----------
    // Checking and report
    // ----------
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic afud_pkg::afud_chr_s mk(input logic u, input logic [15:0] c);
        return {u, 1'b0, c};
    endfunction

    // Work out the characters a record must give, then queue it at the reader
    task automatic add_record(input logic [7:0] r[$]);
        int i;
        int cnt;
        int first;
        logic [15:0] base;
        if (r[0] == afud_pkg::AFUD_HDR_PAIR) begin
            for (i = 1; i + 1 < r.size(); i += 2) begin
                if ({r[i], r[i + 1]} == afud_pkg::AFUD_PAD_PAIR) break;
                exp_q.push_back(mk(1'b1, {r[i], r[i + 1]}));
            end
        end else if (r[0] == afud_pkg::AFUD_HDR_BASE8 || r[0] == afud_pkg::AFUD_HDR_BASE16) begin
            cnt = r[1];
            first = (r[0] == afud_pkg::AFUD_HDR_BASE8) ? 3 : 4;
            base = (first == 3) ? {1'b0, r[2], 7'h00} : {r[2], r[3]};
            for (i = first; i < r.size() && i < first + cnt; i++) begin
                exp_q.push_back(r[i][7] ? mk(1'b1, base + {9'h000, r[i][6:0]}) :
                    mk(1'b0, {9'h000, r[i][6:0]}));
            end
        end else begin
            for (i = 0; i < r.size(); i++) begin
                if (r[i] != afud_pkg::AFUD_PAD_OCTET) exp_q.push_back(mk(1'b0, {9'h000, r[i][6:0]}));
            end
        end
        exp_q.push_back(18'h10000);
        u_afud_rec_reader.put_record(r);
    endtask

    // Wait, bounded, until every expected character has been seen
    task automatic wait_drain;
        for (int k = 0; k < 8000 && exp_q.size() != 0; k++) @(negedge i_clk_sys);
        check("left_over", 18'(exp_q.size()), 18'h00000);
    endtask

    // ----------
    // Consumer and monitor
    // ----------
    always @(negedge i_clk_sys) begin
        chr_ready = stall ? 1'b0 : ($urandom_range(3) != 0);
    end

    // A stalled character must hold; each taken one must match in order
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            final_report();
        end else if (i_rst_b && chr_valid === 1'b1) begin
            if (held_ok) check("chr_hold", chr, held);
            if (chr_ready) begin
                check("chr", chr, (exp_q.size() != 0) ? exp_q.pop_front() : 18'h3FFFF);
                held_ok = 1'b0;
            end else begin
                held = chr;
                held_ok = 1'b1;
            end
        end else begin
            held_ok = 1'b0;
        end
    end

    // ----------
    // Main sequence
    // ----------
    initial begin
        i_rst_b = 1'b0;
        slow = 1'b0;
        stall = 1'b0;
        void'($urandom(99));
        repeat (12) @(negedge i_clk_sys);
        check("rst_oct_ready", {17'h00000, oct_ready}, 18'h00000);
        check("rst_chr_valid", {17'h00000, chr_valid}, 18'h00000);
        i_rst_b = 1'b1;
        // Corner records: padded pairs, both base forms, FF inside count, zero count
        rec = {8'h80, 8'h09, 8'h95, 8'h00, 8'h41, 8'hFF, 8'hFF, 8'hFF};
        add_record(rec);
        rec = {8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h41, 8'hFF, 8'hFF};
        add_record(rec);
        rec = {8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31};
        add_record(rec);
        rec = {8'h81, 8'h00, 8'h13, 8'hFF};
        add_record(rec);
        rec = {8'h82, 8'h01, 8'h7F, 8'hFF, 8'hFF, 8'h2D};
        add_record(rec);
        rec = {8'h53, 8'h41, 8'hFF, 8'hFF};
        add_record(rec);
        rec = {8'h80, 8'h12};
        add_record(rec);
        wait_drain();
        // Full buffer: consumer stalls, so the decoder must stop taking octets
        @(posedge i_clk_sys);
        stall = 1'b1;
        rec = {8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A};
        add_record(rec);
        repeat (40) @(negedge i_clk_sys);
        check("full_oct_ready", {17'h00000, oct_ready}, 18'h00000);
        check("full_chr_valid", {17'h00000, chr_valid}, 18'h00001);
        @(posedge i_clk_sys);
        stall = 1'b0;
        wait_drain();
        // Random records of every scheme, padded with FF
        for (int t = 0; t < 80; t++) begin
            slow = (t >= 40);
            sel = $urandom_range(3);
            rec = {};
            if (sel == 0) begin
                rec.push_back(afud_pkg::AFUD_HDR_PAIR);
                n = $urandom_range(4);
                for (int k = 0; k < 2 * n; k++) rec.push_back(8'($urandom_range(k[0] ? 255 : 254)));
            end else if (sel == 3) begin
                n = 1 + $urandom_range(7);
                for (int k = 0; k < n; k++) rec.push_back(8'($urandom_range(127)));
            end else begin
                n = $urandom_range(6);
                rec.push_back((sel == 1) ? afud_pkg::AFUD_HDR_BASE8 : afud_pkg::AFUD_HDR_BASE16);
                rec.push_back(8'(n));
                for (int k = 0; k < n + sel; k++) rec.push_back(8'($urandom));
            end
            n = $urandom_range(2);
            for (int k = 0; k < n; k++) rec.push_back(afud_pkg::AFUD_PAD_OCTET);
            add_record(rec);
        end
        wait_drain();
        final_report();
    end
endmodule
